// File: rtl/fdc_cfg_defs.svh
`ifndef FDC_CFG_DEFS_SVH
`define FDC_CFG_DEFS_SVH

// ****************************************
// Register indices and reset values
// ****************************************
`define IDX_SETUP 8'h04
`define IDX_DRV_CTRL 8'h05
`define IDX_DRV_TYPE 8'h06
`define RST_SETUP 8'h00
`define RST_DRV_CTRL 8'h00
`define RST_DRV_TYPE 8'hff
`define DRV_CTRL_WMASK 8'h7f

// ****************************************
// Field positions
// ****************************************
`define B_PUSH_PULL 0
`define B_TRISTATE 1
`define B_NON_BURST 2
`define B_DEN_LO 3
`define B_DEN_HI 4
`define B_SWAP 5
`define B_EXT4 6
`define B_MIDI1 4
`define B_MIDI2 5

// ****************************************
// Parallel and clock constants
// ****************************************
`define ECR_MODE_STD 3'h0
`define ECR_MODE_EPP 3'h4
`define DIV_MIDI 4'hc
`define DIV_NORMAL 4'hd
`endif

// File: rtl/fdc_cfg_pkg.sv
package fdc_cfg_pkg;
   typedef enum logic [1:0] {
      PP_SPP = 2'h0,
      PP_EPP_SPP = 2'h1,
      PP_ECP = 2'h2,
      PP_ECP_EPP = 2'h3
   } pp_mode_t;
   typedef enum logic [1:0] {
      DEN_NORMAL = 2'h0,
      DEN_RSVD = 2'h1,
      DEN_FORCE1 = 2'h2,
      DEN_FORCE0 = 2'h3
   } den_sel_t;
endpackage

// File: rtl/cfg_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
// Decoded control fields from drive control register to pin stage
interface cfg_ctrl_if;
   logic push_pull;
   logic tristate;
   logic non_burst;
   logic swap;
   logic ext4;
   fdc_cfg_pkg::den_sel_t den_sel;
   modport src (output push_pull, tristate, non_burst, swap, ext4, den_sel);
   modport dst (input push_pull, tristate, non_burst, swap, ext4, den_sel);
endinterface
`default_nettype wire

// File: rtl/serial_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cfg_defs.svh"
// Serial clock divider, 12 with MIDI, 13 without
module serial_clk_div (
   input wire logic clk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire logic ce_in, // Clock enable
   input wire logic midi_in, // MIDI select
   output logic tick_out // Divided clock pulse
);
   logic [3:0] cnt_r;
   logic [3:0] div_nxt;

   // Divisor choice
   always_comb begin
      div_nxt = midi_in ? `DIV_MIDI : `DIV_NORMAL;
   end

   // Counter and tick
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_r <= 4'h0;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         if (cnt_r >= div_nxt - 4'h1) begin
            cnt_r <= 4'h0;
            tick_out <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 4'h1;
            tick_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/fdc_pin_stage.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cfg_defs.svh"
// Floppy output pin drivers: swap, decode, density, drive type
module fdc_pin_stage (
   input wire logic clk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire logic ce_in, // Clock enable
   cfg_ctrl_if.dst ctl, // Control fields
   input wire logic pp_floppy_in, // Floppy on parallel pins
   input wire logic force_high_in, // Density force bit
   input wire logic den_func_in, // Core density function
   input wire logic [1:0] drv_sel_in, // Core drive number
   input wire logic sel_en_in, // Core select active
   input wire logic motor_in, // Core motor on
   input wire logic [7:0] type_ids_in, // Drive type register
   output logic den_o_out, // Density output level
   output logic den_oe_n_out, // Density enable, low drives
   output logic [3:0] sel_o_out, // Select outputs, active low
   output logic [3:0] sel_oe_n_out, // Select enables, low drives
   output logic [1:0] type_out // Selected drive type
);
   logic [1:0] drv_nxt;
   logic [3:0] sel_nxt;
   logic den_nxt;
   logic pp_nxt;
   logic tri_nxt;

   // Per-pin output enable: open drain drives only low
   function automatic logic oe_n(input logic lvl, input logic pp,
                                 input logic tri_st);
      oe_n = tri_st | (~pp & lvl);
   endfunction

   always_comb begin
      drv_nxt = drv_sel_in;
      if (ctl.swap && !drv_sel_in[1]) begin
         drv_nxt = {1'b0, ~drv_sel_in[0]};
      end
      sel_nxt = 4'hf;
      if (sel_en_in) begin
         if (ctl.ext4) begin
            sel_nxt = {2'h3, ~drv_nxt};
         end else if (!drv_nxt[1]) begin
            sel_nxt[drv_nxt] = 1'b0;
         end
      end
      sel_nxt[3] = sel_nxt[3] & ~(motor_in & ~ctl.ext4);
      case (ctl.den_sel)
         fdc_cfg_pkg::DEN_FORCE1: den_nxt = 1'b1;
         fdc_cfg_pkg::DEN_FORCE0: den_nxt = 1'b0;
         default: den_nxt = force_high_in | den_func_in;
      endcase
      pp_nxt = ctl.push_pull | pp_floppy_in;
      tri_nxt = ctl.tristate & ~pp_floppy_in;
   end

   // Registered pins
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         den_o_out <= 1'b1;
         den_oe_n_out <= 1'b1;
         sel_o_out <= 4'hf;
         sel_oe_n_out <= 4'hf;
         type_out <= 2'h3;
      end else if (ce_in) begin
         den_o_out <= den_nxt;
         den_oe_n_out <= oe_n(den_nxt, pp_nxt, tri_nxt);
         sel_o_out <= sel_nxt;
         for (int i = 0; i < 4; i++) begin
            sel_oe_n_out[i] <= oe_n(sel_nxt[i], pp_nxt, tri_nxt);
         end
         type_out <= type_ids_in[{drv_nxt, 1'b0} +: 2];
      end
   end
endmodule
`default_nettype wire

// File: rtl/fdc_drive_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cfg_defs.svh"
// ****************************************
// Floppy drive configuration registers
// ****************************************
module fdc_drive_config_registers (
   input wire logic clk_in, // 10 MHz clock
   input wire logic sys_rst_in, // Power-on reset
   input wire logic ce_in, // Clock enable
   input wire logic cfg_mode_in, // Configuration state
   input wire logic idx_wr_in, // Index register write strobe
   input wire logic data_wr_in, // Data register write strobe
   input wire logic [7:0] wdata_in, // Write data
   input wire logic pp_floppy_in, // Floppy on parallel pins
   input wire logic force_high_in, // Density force bit
   input wire logic den_func_in, // Core density function
   input wire logic [1:0] drv_sel_in, // Core drive number
   input wire logic sel_en_in, // Core select active
   input wire logic motor_in, // Core motor on
   input wire logic dma_req_in, // Core DMA request
   input wire logic irq_in, // Core interrupt
   input wire logic byte_done_in, // Byte transferred
   input wire logic fifo_en_in, // FIFO enabled
   input wire logic [2:0] ecr_mode_in, // Extended control mode
   output logic [7:0] rdata_out, // Read data of indexed reg
   output logic [7:0] drv_ctrl_out, // Drive control value
   output logic [7:0] drv_type_out, // Drive type value
   output logic den_o_out, // Density output level
   output logic den_oe_n_out, // Density enable, low drives
   output logic [3:0] sel_o_out, // Drive selects
   output logic [3:0] sel_oe_n_out, // Select enables, low drives
   output logic [1:0] type_out, // Selected drive type
   output logic dma_req_out, // DMA request pin
   output logic irq_out, // Interrupt pin
   output logic epp_sel_out, // Enhanced mode selected
   output logic spp_sel_out, // Standard mode selected
   output logic ser1_tick_out, // Serial port 1 clock
   output logic ser2_tick_out // Serial port 2 clock
);
   logic [7:0] index_r;
   logic [7:0] setup_r;
   logic [7:0] drv_ctrl_r;
   logic [7:0] drv_type_r;
   logic [7:0] rd_nxt;
   fdc_cfg_pkg::pp_mode_t pp_mode;
   cfg_ctrl_if ctl_if ();

   // Register access qualifier
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] k);
      hit = (idx == k);
   endfunction

   // ****************************************
   // Index and register writes
   // ****************************************
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         index_r <= 8'h00;
      end else if (ce_in && cfg_mode_in && idx_wr_in) begin
         index_r <= wdata_in;
      end
   end

   // Setup register, bit 7 reserved
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         setup_r <= `RST_SETUP;
      end else if (ce_in && cfg_mode_in && data_wr_in &&
                   hit(index_r, `IDX_SETUP)) begin
         setup_r <= wdata_in & 8'h7f;
      end
   end

   // Drive control register
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         drv_ctrl_r <= `RST_DRV_CTRL;
      end else if (ce_in && cfg_mode_in && data_wr_in &&
                   hit(index_r, `IDX_DRV_CTRL)) begin
         drv_ctrl_r <= wdata_in & `DRV_CTRL_WMASK;
      end
   end

   // Drive type register
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         drv_type_r <= `RST_DRV_TYPE;
      end else if (ce_in && cfg_mode_in && data_wr_in &&
                   hit(index_r, `IDX_DRV_TYPE)) begin
         drv_type_r <= wdata_in;
      end
   end

   // ****************************************
   // Readback
   // ****************************************
   always_comb begin
      rd_nxt = 8'h00;
      if (cfg_mode_in) begin
         case (index_r)
            `IDX_SETUP: rd_nxt = setup_r;
            `IDX_DRV_CTRL: rd_nxt = drv_ctrl_r;
            `IDX_DRV_TYPE: rd_nxt = drv_type_r;
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_out <= 8'h00;
         drv_ctrl_out <= `RST_DRV_CTRL;
         drv_type_out <= `RST_DRV_TYPE;
      end else if (ce_in) begin
         rdata_out <= rd_nxt;
         drv_ctrl_out <= drv_ctrl_r;
         drv_type_out <= drv_type_r;
      end
   end

   // ****************************************
   // Field decode to pin stage
   // ****************************************
   assign ctl_if.push_pull = drv_ctrl_r[`B_PUSH_PULL];
   assign ctl_if.tristate = drv_ctrl_r[`B_TRISTATE];
   assign ctl_if.non_burst = drv_ctrl_r[`B_NON_BURST];
   assign ctl_if.swap = drv_ctrl_r[`B_SWAP];
   assign ctl_if.ext4 = drv_ctrl_r[`B_EXT4];
   assign ctl_if.den_sel = fdc_cfg_pkg::den_sel_t'(
      drv_ctrl_r[`B_DEN_HI:`B_DEN_LO]);

   fdc_pin_stage u_pins (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .ctl(ctl_if.dst),
      .pp_floppy_in(pp_floppy_in),
      .force_high_in(force_high_in),
      .den_func_in(den_func_in),
      .drv_sel_in(drv_sel_in),
      .sel_en_in(sel_en_in),
      .motor_in(motor_in),
      .type_ids_in(drv_type_r),
      .den_o_out(den_o_out),
      .den_oe_n_out(den_oe_n_out),
      .sel_o_out(sel_o_out),
      .sel_oe_n_out(sel_oe_n_out),
      .type_out(type_out)
   );

   // ****************************************
   // DMA mode: burst or one strobe per byte
   // ****************************************
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dma_req_out <= 1'b0;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         if (ctl_if.non_burst && fifo_en_in) begin
            dma_req_out <= dma_req_in & byte_done_in;
            irq_out <= irq_in & byte_done_in;
         end else begin
            dma_req_out <= dma_req_in;
            irq_out <= irq_in;
         end
      end
   end

   // ****************************************
   // Parallel mode select
   // ****************************************
   assign pp_mode = fdc_cfg_pkg::pp_mode_t'(setup_r[1:0]);

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         epp_sel_out <= 1'b0;
         spp_sel_out <= 1'b1;
      end else if (ce_in) begin
         case (pp_mode)
            fdc_cfg_pkg::PP_SPP: begin
               epp_sel_out <= 1'b0;
               spp_sel_out <= 1'b1;
            end
            fdc_cfg_pkg::PP_EPP_SPP: begin
               epp_sel_out <= 1'b1;
               spp_sel_out <= 1'b1;
            end
            fdc_cfg_pkg::PP_ECP: begin
               epp_sel_out <= 1'b0;
               spp_sel_out <= (ecr_mode_in == `ECR_MODE_STD);
            end
            fdc_cfg_pkg::PP_ECP_EPP: begin
               epp_sel_out <= (ecr_mode_in == `ECR_MODE_EPP);
               spp_sel_out <= (ecr_mode_in == `ECR_MODE_STD);
            end
            default: begin
               epp_sel_out <= 1'b0;
               spp_sel_out <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************
   // Serial clock dividers
   // ****************************************
   serial_clk_div u_div1 (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .midi_in(setup_r[`B_MIDI1]),
      .tick_out(ser1_tick_out)
   );

   serial_clk_div u_div2 (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .midi_in(setup_r[`B_MIDI2]),
      .tick_out(ser2_tick_out)
   );
endmodule
`default_nettype wire

// File: dv/floppy_cable_model.sv
`timescale 1ns/1ps
`default_nettype none
// Floppy cable, every line pulled up at the drive end
module floppy_cable_model (
   input wire logic den_o_in, // Density level
   input wire logic den_oe_n_in, // Density enable
   input wire logic [3:0] sel_o_in, // Select levels
   input wire logic [3:0] sel_oe_n_in, // Select enables
   output logic den_pin_out, // Density wire
   output logic [3:0] sel_pin_out // Select wires
);
   // Released lines float up to the pull-up level
   assign den_pin_out = den_oe_n_in ? 1'h1 : den_o_in;
   assign sel_pin_out = sel_oe_n_in | sel_o_in;
endmodule
`default_nettype wire

// File: dv/fdc_cfg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks for drive config registers
// ****************************************
module fdc_cfg_assertions (
   input wire logic clk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire logic cfg_mode_in, // Config state
   input wire logic pp_floppy_in, // Parallel floppy
   input wire logic force_high_in, // Density force
   input wire logic fifo_en_in, // FIFO on
   input wire logic byte_done_in, // Byte strobe
   input wire logic [7:0] drv_ctrl_out, // Control copy
   input wire logic [7:0] drv_type_out, // Type copy
   input wire logic den_o_out, // Density level
   input wire logic den_oe_n_out, // Density enable
   input wire logic [3:0] sel_o_out, // Select levels
   input wire logic [3:0] sel_oe_n_out, // Select enables
   input wire logic dma_req_out, // DMA pin
   input wire logic irq_out, // Interrupt pin
   input wire logic ser1_tick_out // Serial 1 clock
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // Register values, access and reserved bit
   a_reset_vals: assert property ($fell(sys_rst_in) |->
      drv_ctrl_out == 8'h00 && drv_type_out == 8'hff)
      else $error("register value after reset wrong");
   a_bit7_zero: assert property (!drv_ctrl_out[7])
      else $error("reserved control bit set");
   a_no_cfg_hold: assert property ((!cfg_mode_in) [*3] |->
      $stable(drv_ctrl_out) && $stable(drv_type_out))
      else $error("register changed outside config state");

   // Output drivers and density pin
   a_tristate_off: assert property ((drv_ctrl_out[1] &&
      !pp_floppy_in) [*2] |-> den_oe_n_out && sel_oe_n_out == 4'hf)
      else $error("floppy outputs driven while tri-stated");
   a_open_drain: assert property ((!drv_ctrl_out[0] &&
      !pp_floppy_in) [*2] |->
      !(~den_oe_n_out & den_o_out) && (~sel_oe_n_out & sel_o_out) == 4'h0)
      else $error("open drain output driven high");
   a_push_pull: assert property ((drv_ctrl_out[1:0] == 2'h1 &&
      !pp_floppy_in) [*2] |-> !den_oe_n_out)
      else $error("push-pull density not driven");
   a_force_high: assert property ((drv_ctrl_out[4:1] == 4'h0 &&
      force_high_in) [*2] |-> den_o_out)
      else $error("density not held high");
   a_den_forced: assert property ((drv_ctrl_out[4:3] == 2'h3) [*2]
      |-> !den_o_out)
      else $error("density not forced low");

   // Non-burst strobes and serial clock
   a_per_byte: assert property ((drv_ctrl_out[2] && fifo_en_in &&
      !byte_done_in) [*2] |-> !dma_req_out && !irq_out)
      else $error("strobe without byte in non-burst mode");
   a_tick_quiet: assert property (ser1_tick_out |=>
      (!ser1_tick_out) [*8])
      else $error("serial clock ticks too close");
   a_tick_due: assert property (ser1_tick_out |-> ##[1:13]
      ser1_tick_out)
      else $error("serial clock tick overdue");
endmodule

bind fdc_drive_config_registers fdc_cfg_assertions chk (.*);
`default_nettype wire

// File: dv/fdc_drive_config_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_config_registers_tb;
   logic clk_in = 1'h0, sys_rst_in = 1'h1, ce_in = 1'h1, cfg_mode_in = 1'h1;
   logic idx_wr_in = 1'h0, data_wr_in = 1'h0, pp_floppy_in = 1'h0;
   logic force_high_in = 1'h0, den_func_in = 1'h0, sel_en_in = 1'h1;
   logic motor_in = 1'h0, dma_req_in = 1'h0, irq_in = 1'h0;
   logic byte_done_in = 1'h0, fifo_en_in = 1'h0;
   logic [7:0] wdata_in = 8'h00, rdata_out, drv_ctrl_out, drv_type_out;
   logic [1:0] drv_sel_in = 2'h0, type_out;
   logic [2:0] ecr_mode_in = 3'h0;
   logic den_o_out, den_oe_n_out, dma_req_out, irq_out, den_pin;
   logic [3:0] sel_o_out, sel_oe_n_out, sel_pin;
   logic epp_sel_out, spp_sel_out, ser1_tick_out, ser2_tick_out;
   int n_fail = 0, checks_done = 0;

   // Free-running 10 MHz clock
   always #50 clk_in = ~clk_in;

   fdc_drive_config_registers dut (.*);
   floppy_cable_model cable (.den_o_in(den_o_out),
      .den_oe_n_in(den_oe_n_out), .sel_o_in(sel_o_out),
      .sel_oe_n_in(sel_oe_n_out), .den_pin_out(den_pin),
      .sel_pin_out(sel_pin));

   // ****************************************
   // Host access and compare tasks
   // ****************************************
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic wr(input logic [7:0] idx, d);
      idx_wr_in = 1'h1;
      wdata_in = idx;
      cyc(1);
      idx_wr_in = 1'h0;
      data_wr_in = 1'h1;
      wdata_in = d;
      cyc(1);
      data_wr_in = 1'h0;
      cyc(3);
   endtask
   task automatic rd(input logic [7:0] idx, e);
      idx_wr_in = 1'h1;
      wdata_in = idx;
      cyc(1);
      idx_wr_in = 1'h0;
      cyc(2);
      chk("read data", e, rdata_out);
   endtask
   task automatic den(input logic [7:0] c, input logic f, u,
                      input logic [1:0] e);
      force_high_in = f;
      den_func_in = u;
      wr(8'h05, c);
      chk("density pin and enable", 8'(e), 8'({den_pin, den_oe_n_out}));
   endtask
   task automatic sel(input logic [7:0] c, input logic [1:0] d, e);
      drv_sel_in = d;
      wr(8'h05, c);
      chk("select pins", 8'(e), 8'(sel_pin[1:0]));
   endtask
   // Cycles between two serial ticks, bounded
   task automatic gap(input logic s2, input int e);
      int n;
      n = 0;
      while (!(s2 ? ser2_tick_out : ser1_tick_out) && n < 30) begin
         cyc(1);
         n++;
      end
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (!(s2 ? ser2_tick_out : ser1_tick_out) && n < 30);
      chk("tick gap", 8'(e), 8'(n));
      if (n >= 30) give_verdict();
   endtask

   // Main sequence, inputs change at falling edges
   initial begin
      cyc(12);
      sys_rst_in = 1'h0;
      cyc(1);
      chk("control copy", 8'h00, drv_ctrl_out);
      chk("type copy", 8'hff, drv_type_out);
      chk("standard select", 8'h01, 8'(spp_sel_out));
      rd(8'h05, 8'h00);
      rd(8'h06, 8'hff);
      rd(8'h07, 8'h00);
      cfg_mode_in = 1'h0;
      wr(8'h06, 8'h00);
      cfg_mode_in = 1'h1;
      rd(8'h06, 8'hff);
      wr(8'h06, 8'he4);
      for (int i = 0; i < 4; i++) begin
         drv_sel_in = 2'(i);
         cyc(3);
         chk("drive type", 8'(i), 8'(type_out));
      end
      wr(8'h05, 8'hff);
      rd(8'h05, 8'h7f);
      $display("access test done");
      force_high_in = 1'h1;
      cyc(3);
      chk("tristate enables", 8'h1f,
         {3'h0, den_oe_n_out, sel_oe_n_out});
      pp_floppy_in = 1'h1;
      cyc(3);
      chk("parallel floppy enable", 8'h00, 8'(den_oe_n_out));
      pp_floppy_in = 1'h0;
      den(8'h00, 1'h0, 1'h1, 2'h3);
      den(8'h00, 1'h0, 1'h0, 2'h0);
      den(8'h01, 1'h0, 1'h1, 2'h2);
      den(8'h00, 1'h1, 1'h0, 2'h3);
      den(8'h10, 1'h0, 1'h0, 2'h3);
      den(8'h18, 1'h0, 1'h1, 2'h0);
      den(8'h19, 1'h1, 1'h1, 2'h0);
      den(8'h08, 1'h1, 1'h0, 2'h3);
      $display("density test done");
      sel(8'h00, 2'h0, 2'h2);
      sel(8'h00, 2'h1, 2'h1);
      sel(8'h20, 2'h0, 2'h1);
      sel(8'h20, 2'h1, 2'h2);
      sel(8'h00, 2'h2, 2'h3);
      sel(8'h40, 2'h2, 2'h1);
      sel(8'h40, 2'h1, 2'h2);
      $display("select test done");
      wr(8'h05, 8'h04);
      fifo_en_in = 1'h1;
      dma_req_in = 1'h1;
      irq_in = 1'h1;
      cyc(3);
      chk("strobes idle", 8'h00, 8'({dma_req_out, irq_out}));
      byte_done_in = 1'h1;
      cyc(1);
      chk("strobes per byte", 8'h03, 8'({dma_req_out, irq_out}));
      byte_done_in = 1'h0;
      cyc(1);
      chk("strobes after byte", 8'h00, 8'({dma_req_out, irq_out}));
      wr(8'h05, 8'h00);
      chk("burst requests", 8'h03, 8'({dma_req_out, irq_out}));
      $display("dma test done");
      wr(8'h05, 8'h21);
      sys_rst_in = 1'h1;
      cyc(2);
      sys_rst_in = 1'h0;
      cyc(1);
      chk("type copy after reset", 8'hff, drv_type_out);
      rd(8'h05, 8'h00);
      $display("reset test done");
      wr(8'h04, 8'h01);
      chk("mode 01 selects", 8'h03, 8'({epp_sel_out, spp_sel_out}));
      ecr_mode_in = 3'h4;
      wr(8'h04, 8'h02);
      chk("mode 10 selects", 8'h00, 8'({epp_sel_out, spp_sel_out}));
      wr(8'h04, 8'h03);
      chk("enhanced select", 8'h02, 8'({epp_sel_out, spp_sel_out}));
      ecr_mode_in = 3'h0;
      cyc(3);
      chk("standard select", 8'h01, 8'({epp_sel_out, spp_sel_out}));
      rd(8'h04, 8'h03);
      $display("parallel test done");
      wr(8'h04, 8'h00);
      cyc(14);
      gap(1'h0, 13);
      wr(8'h04, 8'h30);
      cyc(14);
      gap(1'h0, 12);
      gap(1'h1, 12);
      $display("clock test done");
      give_verdict();
   end
endmodule
`default_nettype wire
